// ### icl_defines.svh
`ifndef ICL_DEFINES_SVH
`define ICL_DEFINES_SVH

// ****************************************
// core-facing constants
// ****************************************
`define ICL_PC_W          13
`define ICL_VECTOR_ADDR   13'h0004
`define ICL_RET_OPCODE    14'h0009
`define ICL_RET_CYCLES    2
`define ICL_NUM_SRC       4

// ****************************************
// control register field positions
// ****************************************
`define ICL_GIE_BIT       7
`define ICL_PGE_BIT       6
`define ICL_TMR_IE_BIT    5
`define ICL_EXT_IE_BIT    4
`define ICL_CHG_IE_BIT    3
`define ICL_TMR_IF_BIT    2
`define ICL_EXT_IF_BIT    1
`define ICL_CHG_IF_BIT    0

// ****************************************
// peripheral register field positions
// ****************************************
`define ICL_CMP_BIT       6

// ****************************************
// reset values
// ****************************************
`define ICL_CTL_RST       8'h00
`define ICL_PFLAG_RST     8'h00
`define ICL_PEN_RST       8'h00

`endif

// ### icl_pkg.sv
package icl_pkg;

    // one pulse per source, index order matches the flag vector
    typedef struct packed {
        logic cmp;
        logic chg;
        logic tmr;
        logic ext;
    } icl_evt_t;

    // software write strobe with its byte
    typedef struct packed {
        logic       wr;
        logic [7:0] data;
    } icl_wr_t;

    // sequencer states, gray along idle-req-entry and idle-return
    typedef enum logic [2:0] {
        ICL_IDLE  = 3'b000,
        ICL_REQ   = 3'b001,
        ICL_ENT   = 3'b011,
        ICL_ENT2  = 3'b010,
        ICL_RET1  = 3'b100,
        ICL_RET2  = 3'b101
    } icl_state_t;

endpackage

// ### icl_flag_cell.sv
`timescale 1ns/1ps
`include "icl_defines.svh"

// sticky flag: hardware set beats software clear in the same cycle
module icl_flag_cell (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // event and software write
    input  wire logic i_set,
    input  wire logic i_wr,
    input  wire logic i_wdata,
    // flag state
    output logic      o_q
);

    logic q_reg;
    logic q_next;

    // set has priority so a simultaneous event is never lost
    always_comb begin
        q_next = q_reg;
        if (i_wr) begin
            q_next = i_wdata;
        end
        if (i_set) begin
            q_next = 1'b1; // RULE_16
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign o_q = q_reg;

endmodule // icl_flag_cell

// ### icl_irq_ctrl.sv
`timescale 1ns/1ps
`include "icl_defines.svh"

// Summary of operation
// [RULE_01] four sources: external edge, timer overflow, port-B change, comparator.
// [RULE_02] global enable at control bit 7 passes unmasked requests, else blocks all.
// [RULE_03] every reset clears the global enable.
// [RULE_04] each source has its own enable that alone can mask it.
// [RULE_05] three flags in control register; comparator flag and enable in peripheral regs.
// [RULE_06] flags set on their event regardless of any enable.
// [RULE_07] on entry clear global enable, push return address, jump to 0004h.
// [RULE_08] edge and port-B events reach the vector in three or four cycles.
// [RULE_09] clearing global enable suppresses next-cycle entry, inserts a no-op, keeps pending; the no-op comes only from i_gie_clear, not a register write.
// [RULE_10] service software clears flags before re-enabling, or it re-enters at once.
// [RULE_11] return opcode 0009h, two cycles, pops stack top and sets global enable.
// [RULE_12] only the return address is saved; working and status registers are not.
// [RULE_13] software keeps its working-register save slot mirrored in both banks; the bench stand-in routine keeps no save slot.
// [RULE_14] comparator also needs the peripheral group enable.
// [RULE_15] request is global enable and the OR of enabled flags, peripherals group-gated.
// [RULE_16] written zero clears a flag unless an event arrives in the same cycle.
module icl_irq_ctrl
    import icl_pkg::*;
(
    // clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    // source events, one cycle pulses
    input  wire icl_evt_t                i_evt,
    // software register writes
    input  wire icl_wr_t                 i_ctl_wr,
    input  wire icl_wr_t                 i_pflag_wr,
    input  wire icl_wr_t                 i_pen_wr,
    // core sequencer
    input  wire logic                    i_op_valid,
    input  wire logic [13:0]             i_opcode,
    input  wire logic                    i_gie_clear,
    input  wire logic [`ICL_PC_W-1:0]    i_ret_addr,
    // register views
    output logic [7:0]                   o_irq_control_reg,
    output logic [7:0]                   o_periph_flag_reg,
    output logic [7:0]                   o_periph_enable_reg,
    // core control
    output logic                         o_irq_req,
    output logic                         o_vector_load,
    output logic [`ICL_PC_W-1:0]         o_vector_addr,
    output logic                         o_stack_push,
    output logic [`ICL_PC_W-1:0]         o_push_addr,
    output logic                         o_stack_pop,
    output logic                         o_insert_nop
);

    // ****************************************
    // flags
    // ****************************************
    logic [`ICL_NUM_SRC-1:0] flag_q;
    logic [`ICL_NUM_SRC-1:0] flag_set;
    logic [`ICL_NUM_SRC-1:0] flag_wr;
    logic [`ICL_NUM_SRC-1:0] flag_wd;

    // index 0 ext, 1 tmr, 2 chg, 3 cmp
    assign flag_set = {i_evt.cmp, i_evt.chg, i_evt.tmr, i_evt.ext}; // RULE_01
    assign flag_wr  = {i_pflag_wr.wr, {3{i_ctl_wr.wr}}};
    assign flag_wd  = {i_pflag_wr.data[`ICL_CMP_BIT],
                       i_ctl_wr.data[`ICL_CHG_IF_BIT],
                       i_ctl_wr.data[`ICL_TMR_IF_BIT],
                       i_ctl_wr.data[`ICL_EXT_IF_BIT]}; // RULE_05

    // flags set whatever the enables say
    genvar gi;
    generate
        for (gi = 0; gi < `ICL_NUM_SRC; gi++) begin : g_flag
            icl_flag_cell u_cell (
                .i_clk   (i_clk),
                .i_rst   (i_rst),
                .i_set   (flag_set[gi]), // RULE_06
                .i_wr    (flag_wr[gi]),
                .i_wdata (flag_wd[gi]),
                .o_q     (flag_q[gi])
            );
        end
    endgenerate

    // ****************************************
    // enables
    // ****************************************
    logic       gie_reg;
    logic       gie_next;
    logic [2:0] en_reg;
    logic [2:0] en_next;
    logic       pge_reg;
    logic       pge_next;
    logic       cmp_en_reg;
    logic       cmp_en_next;

    // ****************************************
    // request and sequencer
    // ****************************************
    icl_state_t             state_reg;
    icl_state_t             state_next;
    logic                   req_comb;
    logic                   gie_clear_evt;
    logic                   ret_op;
    logic                   irq_req_reg;
    logic                   vec_reg;
    logic [`ICL_PC_W-1:0]   vaddr_reg;
    logic                   push_reg;
    logic [`ICL_PC_W-1:0]   paddr_reg;
    logic                   pop_reg;
    logic                   nop_reg;

    // peripheral group needs its own gate on top of the source enable
    assign req_comb = gie_reg & (|(flag_q[2:0] & en_reg) // RULE_15
                      | (flag_q[3] & cmp_en_reg & pge_reg)); // RULE_14

    // an instruction or a register write may drop the global enable
    assign gie_clear_evt = i_gie_clear | (i_ctl_wr.wr & ~i_ctl_wr.data[`ICL_GIE_BIT]);
    assign ret_op = i_op_valid & (i_opcode == `ICL_RET_OPCODE); // RULE_11

    // next state; a request lost to a clear stays in its flag
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ICL_IDLE: begin
                if (ret_op) begin
                    state_next = ICL_RET1;
                end else if (req_comb && !gie_clear_evt) begin
                    state_next = ICL_REQ; // RULE_08
                end
            end
            ICL_REQ: begin
                if (gie_clear_evt || !req_comb) begin
                    state_next = ICL_IDLE; // RULE_09
                end else begin
                    state_next = ICL_ENT; // RULE_08
                end
            end
            ICL_ENT:  state_next = ICL_ENT2;
            ICL_ENT2: state_next = ICL_IDLE;
            ICL_RET1: state_next = ICL_RET2;
            ICL_RET2: state_next = ICL_IDLE;
            default:  state_next = ICL_IDLE;
        endcase
    end

    // enable bits; sequencer effects override software writes
    always_comb begin
        gie_next    = gie_reg;
        en_next     = en_reg;
        pge_next    = pge_reg;
        cmp_en_next = cmp_en_reg;
        if (i_ctl_wr.wr) begin
            gie_next = i_ctl_wr.data[`ICL_GIE_BIT];
            pge_next = i_ctl_wr.data[`ICL_PGE_BIT];
            en_next  = {i_ctl_wr.data[`ICL_CHG_IE_BIT],
                        i_ctl_wr.data[`ICL_TMR_IE_BIT],
                        i_ctl_wr.data[`ICL_EXT_IE_BIT]}; // RULE_04
        end
        if (i_pen_wr.wr) begin
            cmp_en_next = i_pen_wr.data[`ICL_CMP_BIT]; // RULE_05
        end
        if (i_gie_clear) begin
            gie_next = 1'b0; // RULE_09
        end
        if (state_next == ICL_RET2) begin
            gie_next = 1'b1; // RULE_11
        end
        if (state_next == ICL_ENT) begin
            gie_next = 1'b0; // RULE_07
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gie_reg    <= 1'b0; // RULE_03
            en_reg     <= 3'h0;
            pge_reg    <= 1'b0;
            cmp_en_reg <= 1'b0;
        end else begin
            gie_reg    <= gie_next;
            en_reg     <= en_next;
            pge_reg    <= pge_next;
            cmp_en_reg <= cmp_en_next;
        end
    end

    // core strobes registered so every output leaves a flop
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg   <= ICL_IDLE;
            irq_req_reg <= 1'b0;
            vec_reg     <= 1'b0;
            vaddr_reg   <= {`ICL_PC_W{1'b0}};
            push_reg    <= 1'b0;
            paddr_reg   <= {`ICL_PC_W{1'b0}};
            pop_reg     <= 1'b0;
            nop_reg     <= 1'b0;
        end else begin
            state_reg   <= state_next;
            irq_req_reg <= req_comb & ~gie_clear_evt; // RULE_02
            vec_reg     <= (state_next == ICL_ENT);
            vaddr_reg   <= `ICL_VECTOR_ADDR; // RULE_07
            push_reg    <= (state_next == ICL_ENT);
            // only the program counter is saved, nothing else
            paddr_reg   <= (state_next == ICL_ENT) ? i_ret_addr : paddr_reg; // RULE_12
            pop_reg     <= (state_next == ICL_RET1); // RULE_11
            nop_reg     <= i_gie_clear & gie_reg; // RULE_09
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_irq_control_reg   = {gie_reg, pge_reg, en_reg[1], en_reg[0], en_reg[2],
                                  flag_q[1], flag_q[0], flag_q[2]};
    assign o_periph_flag_reg   = {1'b0, flag_q[3], 6'h00};
    assign o_periph_enable_reg = {1'b0, cmp_en_reg, 6'h00};
    assign o_irq_req           = irq_req_reg;
    assign o_vector_load       = vec_reg;
    assign o_vector_addr       = vaddr_reg;
    assign o_stack_push        = push_reg;
    assign o_push_addr         = paddr_reg;
    assign o_stack_pop         = pop_reg;
    assign o_insert_nop        = nop_reg;

    // ****************************************
    // assertions
    // ****************************************
    property p_vec_entry;
        @(posedge i_clk) disable iff (i_rst)
        o_vector_load |-> (o_vector_addr == `ICL_VECTOR_ADDR) && o_stack_push && !gie_reg;
    endproperty
    a_vec_entry: assert property (p_vec_entry) else $error("bad vector entry"); // RULE_07

    property p_push_addr;
        @(posedge i_clk) disable iff (i_rst)
        o_stack_push |-> (o_push_addr == $past(i_ret_addr));
    endproperty
    a_push_addr: assert property (p_push_addr) else $error("wrong return address"); // RULE_12

    property p_ret_gie;
        @(posedge i_clk) disable iff (i_rst)
        o_stack_pop |=> gie_reg && !o_stack_pop;
    endproperty
    a_ret_gie: assert property (p_ret_gie) else $error("return did not enable"); // RULE_11

    property p_nop;
        @(posedge i_clk) disable iff (i_rst)
        o_insert_nop |-> !o_vector_load && !gie_reg ##1 !o_vector_load;
    endproperty
    a_nop: assert property (p_nop) else $error("entry after global clear"); // RULE_09

    property p_flag_set;
        @(posedge i_clk) disable iff (i_rst)
        (i_evt.ext && i_ctl_wr.wr && !i_ctl_wr.data[`ICL_EXT_IF_BIT])
            |=> o_irq_control_reg[`ICL_EXT_IF_BIT];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event lost to clear"); // RULE_16

    property p_cmp_flag;
        @(posedge i_clk) disable iff (i_rst)
        i_evt.cmp |=> o_periph_flag_reg[`ICL_CMP_BIT];
    endproperty
    a_cmp_flag: assert property (p_cmp_flag) else $error("comparator flag missed"); // RULE_06

    // counted from the pin event itself, so a slow sequencer cannot hide
    property p_latency;
        @(posedge i_clk) disable iff (i_rst)
        (i_evt.ext && gie_reg && en_reg[0] && !req_comb && state_reg == ICL_IDLE
            && !i_ctl_wr.wr && !ret_op && !i_gie_clear)
            ##1 (!gie_clear_evt && !ret_op) ##1 !gie_clear_evt |=> o_vector_load;
    endproperty
    a_latency: assert property (p_latency) else $error("entry late"); // RULE_08

    property p_gie_block;
        @(posedge i_clk) disable iff (i_rst)
        !gie_reg |=> !o_irq_req;
    endproperty
    a_gie_block: assert property (p_gie_block) else $error("request without enable"); // RULE_02

    property p_masked;
        @(posedge i_clk) disable iff (i_rst)
        ((flag_q[2:0] & en_reg) == 3'h0 && !(flag_q[3] && cmp_en_reg)) |=> !o_irq_req;
    endproperty
    a_masked: assert property (p_masked) else $error("masked source requested"); // RULE_04

    property p_group;
        @(posedge i_clk) disable iff (i_rst)
        ((flag_q[2:0] & en_reg) == 3'h0 && !pge_reg) |=> !o_irq_req;
    endproperty
    a_group: assert property (p_group) else $error("group gate ignored"); // RULE_14

    c_entry:  cover property (@(posedge i_clk) disable iff (i_rst) o_vector_load);
    c_return: cover property (@(posedge i_clk) disable iff (i_rst) o_stack_pop ##1 gie_reg);
    c_nop:    cover property (@(posedge i_clk) disable iff (i_rst) o_insert_nop && flag_q != 4'h0);
    c_cmp:    cover property (@(posedge i_clk) disable iff (i_rst) o_irq_req && flag_q[3]);

endmodule // icl_irq_ctrl

// ### icl_core_model.sv
`timescale 1ns/1ps
`include "icl_defines.svh"

// ****************************************
// core stand-in: program counter and return stack
// ****************************************
module icl_core_model (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    // controller strobes
    input  wire logic                 i_load,
    input  wire logic [`ICL_PC_W-1:0] i_vec,
    input  wire logic                 i_push,
    input  wire logic [`ICL_PC_W-1:0] i_push_addr,
    input  wire logic                 i_pop,
    // running program counter, also the return address offered
    output logic [`ICL_PC_W-1:0]      o_pc
);
    logic [`ICL_PC_W-1:0] stk_reg [8];
    logic [2:0]           sp_reg;

    // eight deep and circular, so an overflow silently loses the oldest entry
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pc   <= '0;
            sp_reg <= '0;
            // known contents, so a return with nothing pushed pops zero, not unknown
            for (int i = 0; i < 8; i++) begin
                stk_reg[i] <= '0;
            end
        end else begin
            o_pc <= o_pc + 1'b1;
            if (i_push) begin
                stk_reg[sp_reg] <= i_push_addr;
                sp_reg          <= sp_reg + 3'h1;
            end
            if (i_load) begin
                o_pc <= i_vec;
            end
            if (i_pop) begin
                o_pc   <= stk_reg[sp_reg - 3'h1];
                sp_reg <= sp_reg - 3'h1;
            end
        end
    end
endmodule // icl_core_model

// ### interrupt_control_logic_bench.sv
`timescale 1ns/1ps
`include "icl_defines.svh"

module interrupt_control_logic_bench
    import icl_pkg::*;
();
    logic                 i_clk, i_rst, op_valid, gie_clear, nx_op, nx_clr;
    logic [13:0]          opcode, nx_opc;
    icl_evt_t             evt, nx_evt;
    icl_wr_t              ctl_wr, pflag_wr, pen_wr, nx_ctl, nx_pflag, nx_pen;
    logic [`ICL_PC_W-1:0] pc, ret_exp, vaddr, push_addr;
    logic [7:0]           ctl, pflag, pen;
    logic [7:0]           ie_tab [4];
    logic                 irq_req, vload, push, pop, nop;
    int                   error_cnt, num_checks, cyc_cnt;

    icl_irq_ctrl dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_evt(evt),
        .i_ctl_wr(ctl_wr), .i_pflag_wr(pflag_wr), .i_pen_wr(pen_wr),
        .i_op_valid(op_valid), .i_opcode(opcode), .i_gie_clear(gie_clear),
        .i_ret_addr(pc), .o_irq_control_reg(ctl), .o_periph_flag_reg(pflag),
        .o_periph_enable_reg(pen), .o_irq_req(irq_req), .o_vector_load(vload),
        .o_vector_addr(vaddr), .o_stack_push(push), .o_push_addr(push_addr),
        .o_stack_pop(pop), .o_insert_nop(nop)
    );

    icl_core_model core (
        .i_clk(i_clk), .i_rst(i_rst), .i_load(vload), .i_vec(vaddr),
        .i_push(push), .i_push_addr(push_addr), .i_pop(pop), .o_pc(pc)
    );

    // 25 MHz instruction clock
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // staged requests launch on the edge and last one cycle; hang guard
    always @(posedge i_clk) begin
        evt       <= nx_evt;
        ctl_wr    <= nx_ctl;
        pflag_wr  <= nx_pflag;
        pen_wr    <= nx_pen;
        op_valid  <= nx_op;
        opcode    <= nx_opc;
        gie_clear <= nx_clr;
        nx_evt = '0;
        nx_ctl = '0;
        nx_pflag = '0;
        nx_pen = '0;
        nx_op = 1'b0;
        nx_clr = 1'b0;
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // ****************************************
    // access tasks
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // all three registers written in one cycle, visible on return
    task automatic wr(input logic [7:0] c, input logic [7:0] f, input logic [7:0] e);
        nx_ctl = '{1'b1, c};
        nx_pflag = '{1'b1, f};
        nx_pen = '{1'b1, e};
        cyc(2);
    endtask

    // source index 0 ext, 1 tmr, 2 chg, 3 cmp; flag visible on return
    task automatic ev(input int s);
        nx_evt = icl_evt_t'(4'h1 << s);
        cyc(2);
    endtask

    task automatic ret(input logic [13:0] op, input logic exp);
        nx_op = 1'b1;
        nx_opc = op;
        cyc(2);
        chk(pop, exp, "pop");
        cyc(1);
    endtask

    task automatic end_of_test();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        i_rst = 1'b1;
        {evt, ctl_wr, pflag_wr, pen_wr, nx_evt, nx_ctl, nx_pflag, nx_pen} = '0;
        {op_valid, gie_clear, nx_op, nx_clr, opcode, nx_opc} = '0;
        ie_tab = '{8'h10, 8'h20, 8'h08, 8'h40};
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        cyc(1);
        chk({ctl, pflag, pen}, 24'h0, "reset regs");
        chk(vaddr, 13'h0004, "vector addr");
        // flags rise with every enable off
        for (int s = 0; s < 4; s++)
            ev(s);
        chk({pflag, ctl}, 24'h4007, "flags");
        wr(8'h7F, 8'h40, 8'h40);
        chk({ctl, pflag, pen}, 24'h7F4040, "register writes");
        cyc(1);
        chk(irq_req, 1'b0, "gie off");
        nx_evt.ext = 1'b1;
        wr(8'h78, 8'h00, 8'h40);
        chk({pflag, ctl}, 24'h007A, "set beats clear");
        // each source alone: masked neighbour, entry, service, return
        for (int s = 0; s < 4; s++) begin
            wr(8'h80 | ie_tab[s], 8'h00, s == 3 ? 8'h40 : 8'h00);
            ev((s + 1) % 4);
            cyc(1);
            chk(irq_req, 1'b0, "masked source");
            wr(8'h80 | ie_tab[s], 8'h00, s == 3 ? 8'h40 : 8'h00);
            ev(s);
            cyc(1);
            chk(irq_req, 1'b1, "request");
            ret_exp = pc;
            cyc(1);
            chk({vload, push}, 2'b11, "entry strobes");
            chk(push_addr, ret_exp, "saved pc");
            chk(ctl[7], 1'b0, "gie on entry");
            cyc(1);
            chk(pc, 13'h0004, "vector");
            // stand-in routine clears flags, plus the comparator enable on the comparator pass; it keeps no working-register save slot
            wr(ie_tab[s], 8'h00, 8'h00);
            ret(14'h0008, 1'b0);
            ret(14'h0009, 1'b1);
            chk(ctl[7], 1'b1, "gie on return");
            chk(pc, ret_exp, "return pc");
        end
        // comparator without the group enable stays quiet
        wr(8'h80, 8'h00, 8'h40);
        ev(3);
        cyc(1);
        chk(irq_req, 1'b0, "group gate");
        // global clear lands in the slot where the request would form
        wr(8'h90, 8'h00, 8'h00);
        nx_evt.ext = 1'b1;
        cyc(1);
        nx_clr = 1'b1;
        cyc(2);
        chk({nop, irq_req}, 2'b10, "nop slot");
        chk(ctl, 8'h12, "pending");
        cyc(1);
        chk(vload, 1'b0, "no entry");
        ret(14'h0009, 1'b1);
        for (int i = 0; i < 6 && vload !== 1'b1; i++)
            cyc(1);
        chk(vload, 1'b1, "pending entry");
        // a second reset in mid-run drops the global enable
        wr(8'h80, 8'h00, 8'h00);
        @(posedge i_clk);
        i_rst <= 1'b1;
        cyc(2);
        chk(ctl, 8'h00, "gie after reset");
        // release again: enables stay clear, vector address comes back
        @(posedge i_clk);
        i_rst <= 1'b0;
        cyc(2);
        chk({ctl, pflag, pen}, 24'h0, "regs after release");
        chk({irq_req, vaddr}, {1'b0, 13'h0004}, "vector after release");
        end_of_test();
    end
endmodule // interrupt_control_logic_bench
